/* shared/adc_ctl_pkg.sv */
`default_nettype none
package adc_ctl_pkg;
	// ==================================================
	// register map, byte addresses on the bus
	localparam logic [7:0] OFS_CONV_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_INPUT_CLOCK   = 8'h04;
	localparam logic [7:0] OFS_REF_AMP       = 8'h08;
	localparam logic [7:0] OFS_BANDGAP       = 8'h0c;
	localparam logic [7:0] OFS_RESULT_LOW    = 8'h10;
	localparam logic [7:0] OFS_RESULT_HIGH   = 8'h14;
	// ==================================================
	// field positions
	localparam int POS_START       = 7;
	localparam int POS_BUSY        = 6;
	localparam int POS_ENABLE      = 5;
	localparam int POS_ALIGN       = 4;
	localparam int POS_CHAN        = 0;
	localparam int POS_SRC         = 4;
	localparam int POS_DIV         = 0;
	localparam int POS_AMP_EN      = 7;
	localparam int POS_AMP_IN      = 4;
	localparam int POS_REF_SEL     = 2;
	localparam int POS_GAIN        = 0;
	localparam int POS_BG_EN       = 0;
	// ==================================================
	// reset values of every control field
	localparam logic       RST_BIT   = 1'h0;
	localparam logic [3:0] RST_NIB   = 4'h0;
	localparam logic [2:0] RST_DIV   = 3'h0;
	localparam logic [1:0] RST_PAIR  = 2'h0;
	localparam logic [11:0] RST_RES  = 12'h000;
	// ==================================================
	// converter input routing codes
	localparam logic [2:0] ROUTE_EXT     = 3'h0;
	localparam logic [2:0] ROUTE_SUP     = 3'h1;
	localparam logic [2:0] ROUTE_SUP_2   = 3'h2;
	localparam logic [2:0] ROUTE_SUP_4   = 3'h3;
	localparam logic [2:0] ROUTE_AMP     = 3'h4;
	localparam logic [2:0] ROUTE_AMP_2   = 3'h5;
	localparam logic [2:0] ROUTE_AMP_4   = 3'h6;
	localparam logic [2:0] ROUTE_GND     = 3'h7;
	// reference select code that uses the external reference pin
	localparam logic [1:0] REF_EXT_PIN   = 2'h1;
	// ==================================================
	// divider and start sequencer
	localparam int DIV_CNT_W = 7;
	typedef enum logic [1:0] {st_idle, st_armed, st_busy} conv_state_e;
endpackage
`default_nettype wire

/* shared/conv_clk_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// link between the register block and its clock divider
interface conv_clk_if;
	logic       run;  // divider runs while the converter is enabled
	logic [2:0] sel;  // power of two of the division
	logic       tick; // one-cycle conversion clock enable
	modport ctl (output run, output sel, input tick);
	modport div (input run, input sel, output tick);
endinterface
`default_nettype wire

/* logic/conv_clock_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// conversion clock enable: one pulse every 2**sel system clocks
module conv_clock_divider (
	input  wire logic   clock,
	input  wire logic   sys_rst,
	conv_clk_if.div     lnk
);
	typedef struct packed {
		logic [adc_ctl_pkg::DIV_CNT_W-1:0] cnt;  // cycles since last tick
		logic [2:0]                         sel;  // select seen last cycle
		logic                               tick; // registered enable
	} div_s;

	div_s div_ff;  // all divider state
	div_s nxt_div; // its next value
	logic [adc_ctl_pkg::DIV_CNT_W-1:0] lim; // last count of a period

	// ==================================================
	// next state; a change of select restarts the period so that
	// no short or stretched tick leaks through a reprogramming
	always_comb begin
		lim = (adc_ctl_pkg::DIV_CNT_W)'((8'h01 << lnk.sel) - 8'h01);
		nxt_div = div_ff;
		nxt_div.sel = lnk.sel;
		nxt_div.tick = 1'b0;
		if (!lnk.run || lnk.sel != div_ff.sel) begin
			nxt_div.cnt = '0; // held idle while disabled
		end else if (div_ff.cnt >= lim) begin
			nxt_div.cnt = '0;
			nxt_div.tick = 1'b1;
		end else begin
			nxt_div.cnt = div_ff.cnt + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_ff <= '0;
		end else begin
			div_ff <= nxt_div;
		end
	end

	assign lnk.tick = div_ff.tick;

	// after a tick and three quiet cycles at divide-by-four, a tick follows
	property p_div_four;
		@(posedge clock) disable iff (sys_rst)
		// the tick must belong to a period already run at divide-by-four,
		// since a tick left over from the old select restarts the count
		(div_ff.tick && lnk.run && lnk.sel == 3'h2 && div_ff.sel == 3'h2)
		##1 (!div_ff.tick && lnk.run && lnk.sel == 3'h2) [*3]
		##1 (lnk.run && lnk.sel == 3'h2) |-> div_ff.tick;
	endproperty
	a_div_four: assert property (p_div_four) else $error("divider period wrong");
endmodule // conv_clock_divider
`default_nettype wire

/* logic/adc_control_registers.sv */
// Overview of operation
// - Start written high then low launches conversion
// - Busy set on launch, cleared on completion
// - Disabled converter powers down, result held
// - Align bit picks high or low result placement
// - Unused result bits read as zero
// - Channel field passes any of its 16 codes to the external channel select
// - Source field routes supply, amplifier, ground or channel
// - Internal source disconnects the external channel
// - Conversion clock is system clock over 2**field
// - Amplifier enable bit powers the amplifier
// - Bandgap amplifier input disconnects reference input pin
// - Reference select; internal choice disconnects reference pin
// - Gain select sets amplifier gain
// - Bandgap enable bit powers bandgap circuit
// - Unimplemented bits read zero, ignore writes
// - Completion raises interrupt request as busy clears
`timescale 1ns/100ps
`default_nettype none
module adc_control_registers #(
	parameter int ADR_W = 8 // byte address bits used by the decoder
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              core_done,
	input  wire logic [11:0]       core_result,
	output logic                   conv_start,
	output logic                   conv_clk_tick,
	output logic                   conv_power_on,
	output logic                   conv_done_irq,
	output logic      [3:0]        ext_channel_sel,
	output logic                   ext_channel_connect,
	output logic      [2:0]        input_route,
	output logic      [1:0]        ref_source_sel,
	output logic                   ext_ref_pin_connect,
	output logic                   amp_enable,
	output logic                   amp_input_bandgap,
	output logic                   amp_ref_pin_connect,
	output logic      [1:0]        amp_gain_sel,
	output logic                   bandgap_on
);
	// ==================================================
	// state
	typedef struct packed {
		adc_ctl_pkg::conv_state_e fsm;  // start sequencer
		logic        start;  // start control as last written
		logic        enable; // converter enable
		logic        align;  // result placement
		logic [3:0]  chan;   // external channel select
		logic [3:0]  src;    // input source select
		logic [2:0]  div;    // conversion clock divider select
		logic        amp_en; // amplifier enable
		logic        amp_in; // amplifier input select
		logic [1:0]  ref_sel; // reference source select
		logic [1:0]  gain;   // amplifier gain select
		logic        bg_en;  // bandgap enable
		logic [11:0] result; // last conversion result
		logic        launch; // one-cycle start toward the core
		logic        irq;    // one-cycle completion request
		logic        ack;    // bus acknowledge
		logic [31:0] rdata;  // read data held for the master
	} regs_s;

	regs_s regs_ff;  // every flip-flop of the block
	regs_s nxt_regs; // their next values

	logic       acc;      // a bus request is pending
	logic       wr_commit; // write takes effect at this edge
	logic [7:0] wbyte;    // low byte lane of write data
	logic       busy;     // conversion in progress
	logic [7:0] rbyte;    // selected register contents
	conv_clk_if clk_lnk (); // link to the divider

	// ==================================================
	// decode of the input source field into a route code
	function automatic logic [2:0] route_of(input logic [3:0] s);
		logic [2:0] r;
		r = adc_ctl_pkg::ROUTE_EXT;
		case (s)
			4'h1:    r = adc_ctl_pkg::ROUTE_SUP;
			4'h2:    r = adc_ctl_pkg::ROUTE_SUP_2;
			4'h3:    r = adc_ctl_pkg::ROUTE_SUP_4;
			4'h5:    r = adc_ctl_pkg::ROUTE_AMP;
			4'h6:    r = adc_ctl_pkg::ROUTE_AMP_2;
			4'h7:    r = adc_ctl_pkg::ROUTE_AMP_4;
			4'h8, 4'h9, 4'ha, 4'hb: r = adc_ctl_pkg::ROUTE_GND;
			default: r = adc_ctl_pkg::ROUTE_EXT; // 0000, 0100 and 11xx
		endcase
		return r;
	endfunction

	// ==================================================
	// bus qualifiers; the write lands on the edge that sees ack high,
	// the same edge at which the master samples the answer
	assign acc = wb_cyc_i && wb_stb_i;
	assign wr_commit = acc && wb_we_i && regs_ff.ack && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign busy = (regs_ff.fsm == adc_ctl_pkg::st_busy);

	// ==================================================
	// read multiplexer; result placement follows the align bit
	always_comb begin
		rbyte = 8'h00; // unmapped addresses read zero
		case (wb_adr_i)
			adc_ctl_pkg::OFS_CONV_CONTROL:
				rbyte = {regs_ff.start, busy, regs_ff.enable,
				         regs_ff.align, regs_ff.chan};
			adc_ctl_pkg::OFS_INPUT_CLOCK:
				rbyte = {regs_ff.src, 1'b0, regs_ff.div};
			adc_ctl_pkg::OFS_REF_AMP:
				rbyte = {regs_ff.amp_en, 2'b00, regs_ff.amp_in,
				         regs_ff.ref_sel, regs_ff.gain};
			adc_ctl_pkg::OFS_BANDGAP:
				rbyte = {7'h00, regs_ff.bg_en};
			adc_ctl_pkg::OFS_RESULT_LOW: begin
				if (regs_ff.align) begin
					rbyte = regs_ff.result[7:0];
				end else begin
					rbyte = {regs_ff.result[3:0], 4'h0};
				end
			end
			adc_ctl_pkg::OFS_RESULT_HIGH: begin
				if (regs_ff.align) begin
					rbyte = {4'h0, regs_ff.result[11:8]};
				end else begin
					rbyte = regs_ff.result[11:4];
				end
			end
			default: rbyte = 8'h00;
		endcase
	end

	// ==================================================
	// next-state logic for registers, sequencer and bus answer
	always_comb begin
		nxt_regs = regs_ff;
		nxt_regs.launch = 1'b0;
		nxt_regs.irq = 1'b0;
		// ack rises one cycle after the request and drops right after
		nxt_regs.ack = acc && !regs_ff.ack;
		if (acc && !regs_ff.ack) begin
			nxt_regs.rdata = {24'h000000, rbyte};
		end

		// register writes; busy bit and result are read-only
		if (wr_commit) begin
			case (wb_adr_i)
				adc_ctl_pkg::OFS_CONV_CONTROL: begin
					nxt_regs.start  = wbyte[adc_ctl_pkg::POS_START];
					nxt_regs.enable = wbyte[adc_ctl_pkg::POS_ENABLE];
					nxt_regs.align  = wbyte[adc_ctl_pkg::POS_ALIGN];
					nxt_regs.chan   = wbyte[adc_ctl_pkg::POS_CHAN +: 4];
				end
				adc_ctl_pkg::OFS_INPUT_CLOCK: begin
					nxt_regs.src = wbyte[adc_ctl_pkg::POS_SRC +: 4];
					nxt_regs.div = wbyte[adc_ctl_pkg::POS_DIV +: 3];
				end
				adc_ctl_pkg::OFS_REF_AMP: begin
					nxt_regs.amp_en  = wbyte[adc_ctl_pkg::POS_AMP_EN];
					nxt_regs.amp_in  = wbyte[adc_ctl_pkg::POS_AMP_IN];
					nxt_regs.ref_sel = wbyte[adc_ctl_pkg::POS_REF_SEL +: 2];
					nxt_regs.gain    = wbyte[adc_ctl_pkg::POS_GAIN +: 2];
				end
				adc_ctl_pkg::OFS_BANDGAP: begin
					nxt_regs.bg_en = wbyte[adc_ctl_pkg::POS_BG_EN];
				end
				default: begin
					// result and unmapped words ignore writes
				end
			endcase
		end

		// start sequencer: a rise arms, the following fall launches
		case (regs_ff.fsm)
			adc_ctl_pkg::st_idle: begin
				if (wr_commit && wb_adr_i == adc_ctl_pkg::OFS_CONV_CONTROL &&
				    wbyte[adc_ctl_pkg::POS_START] && !regs_ff.start &&
				    regs_ff.enable) begin
					nxt_regs.fsm = adc_ctl_pkg::st_armed;
				end
			end
			adc_ctl_pkg::st_armed: begin
				if (!regs_ff.enable) begin
					nxt_regs.fsm = adc_ctl_pkg::st_idle;
				end else if (wr_commit &&
				             wb_adr_i == adc_ctl_pkg::OFS_CONV_CONTROL &&
				             !wbyte[adc_ctl_pkg::POS_START]) begin
					// busy shows from the next cycle on
					nxt_regs.fsm = adc_ctl_pkg::st_busy;
					nxt_regs.launch = 1'b1;
				end
			end
			adc_ctl_pkg::st_busy: begin
				if (!regs_ff.enable) begin
					// powering down abandons the conversion, result kept
					nxt_regs.fsm = adc_ctl_pkg::st_idle;
				end else if (core_done) begin
					nxt_regs.fsm = adc_ctl_pkg::st_idle;
					nxt_regs.result = core_result;
					nxt_regs.irq = 1'b1;
				end
			end
			default: nxt_regs.fsm = adc_ctl_pkg::st_idle;
		endcase
	end

	// ==================================================
	// state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			regs_ff <= '{fsm: adc_ctl_pkg::st_idle,
			             start: adc_ctl_pkg::RST_BIT,
			             enable: adc_ctl_pkg::RST_BIT,
			             align: adc_ctl_pkg::RST_BIT,
			             chan: adc_ctl_pkg::RST_NIB,
			             src: adc_ctl_pkg::RST_NIB,
			             div: adc_ctl_pkg::RST_DIV,
			             amp_en: adc_ctl_pkg::RST_BIT,
			             amp_in: adc_ctl_pkg::RST_BIT,
			             ref_sel: adc_ctl_pkg::RST_PAIR,
			             gain: adc_ctl_pkg::RST_PAIR,
			             bg_en: adc_ctl_pkg::RST_BIT,
			             result: adc_ctl_pkg::RST_RES,
			             launch: 1'b0,
			             irq: 1'b0,
			             ack: 1'b0,
			             rdata: 32'h00000000};
		end else begin
			regs_ff <= nxt_regs;
		end
	end

	// ==================================================
	// conversion clock divider, running only while enabled
	assign clk_lnk.run = regs_ff.enable;
	assign clk_lnk.sel = regs_ff.div;

	conv_clock_divider u_div (
		.clock   (clock),
		.sys_rst (sys_rst),
		.lnk     (clk_lnk.div)
	);

	// ==================================================
	// outputs toward the analog side and the bus
	assign wb_ack_o = regs_ff.ack;
	assign wb_dat_o = regs_ff.rdata;
	assign conv_start = regs_ff.launch;
	assign conv_clk_tick = clk_lnk.tick;
	assign conv_power_on = regs_ff.enable;
	assign conv_done_irq = regs_ff.irq;
	assign ext_channel_sel = regs_ff.chan;
	assign input_route = route_of(regs_ff.src);
	// external channel is cut whenever any internal signal is routed
	assign ext_channel_connect =
		(route_of(regs_ff.src) == adc_ctl_pkg::ROUTE_EXT);
	assign ref_source_sel = regs_ff.ref_sel;
	assign ext_ref_pin_connect =
		(regs_ff.ref_sel == adc_ctl_pkg::REF_EXT_PIN);
	assign amp_enable = regs_ff.amp_en;
	// bandgap readiness is software's job; hardware only switches the pin
	assign amp_input_bandgap = regs_ff.amp_in;
	assign amp_ref_pin_connect = !regs_ff.amp_in;
	assign amp_gain_sel = regs_ff.gain;
	assign bandgap_on = regs_ff.bg_en;

	// ==================================================
	// checks
	property p_launch;
		@(posedge clock) disable iff (sys_rst)
		(regs_ff.fsm == adc_ctl_pkg::st_armed && regs_ff.enable && wr_commit &&
		 wb_adr_i == adc_ctl_pkg::OFS_CONV_CONTROL &&
		 !wbyte[adc_ctl_pkg::POS_START]) |=> (busy && conv_start);
	endproperty
	a_launch: assert property (p_launch) else $error("no launch after start fall");

	property p_busy_hold;
		@(posedge clock) disable iff (sys_rst)
		(busy && !core_done && regs_ff.enable) |=> busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

	property p_done;
		@(posedge clock) disable iff (sys_rst)
		(busy && core_done && regs_ff.enable) |=>
			(!busy && conv_done_irq && regs_ff.result == $past(core_result));
	endproperty
	a_done: assert property (p_done) else $error("completion not handled");

	property p_irq_with_clear;
		@(posedge clock) disable iff (sys_rst)
		conv_done_irq |-> ($fell(busy) ##1 !conv_done_irq);
	endproperty
	a_irq_with_clear: assert property (p_irq_with_clear) else $error("irq not with busy clear");

	property p_hold_disabled;
		@(posedge clock) disable iff (sys_rst)
		!regs_ff.enable |=> $stable(regs_ff.result);
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("result changed while off");

	property p_no_start_disabled;
		@(posedge clock) disable iff (sys_rst)
		(!regs_ff.enable && !busy) |=> (!busy && !conv_start) [*2];
	endproperty
	a_no_start_disabled: assert property (p_no_start_disabled) else $error("start while off");

	property p_align_read;
		@(posedge clock) disable iff (sys_rst)
		(acc && !regs_ff.ack && !wb_we_i && !regs_ff.align &&
		 wb_adr_i == adc_ctl_pkg::OFS_RESULT_HIGH) |=>
			(wb_ack_o && wb_dat_o == {24'h000000, $past(regs_ff.result[11:4])});
	endproperty
	a_align_read: assert property (p_align_read) else $error("high byte placement");

	property p_zero_fill;
		@(posedge clock) disable iff (sys_rst)
		(acc && !regs_ff.ack && !wb_we_i && regs_ff.align &&
		 wb_adr_i == adc_ctl_pkg::OFS_RESULT_HIGH) |=> (wb_dat_o[31:4] == 28'h0000000);
	endproperty
	a_zero_fill: assert property (p_zero_fill) else $error("unused result bits set");

	property p_ext_cut;
		@(posedge clock) disable iff (sys_rst)
		(regs_ff.src inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
		                     4'h8, 4'h9, 4'ha, 4'hb}) |->
			(!ext_channel_connect && input_route != adc_ctl_pkg::ROUTE_EXT);
	endproperty
	a_ext_cut: assert property (p_ext_cut) else $error("external channel left on");

	property p_unimpl_zero;
		@(posedge clock) disable iff (sys_rst)
		(acc && !regs_ff.ack && !wb_we_i && wb_adr_i == adc_ctl_pkg::OFS_REF_AMP) |=>
			(wb_dat_o[6:5] == 2'b00 && wb_dat_o[31:8] == 24'h000000);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bits nonzero");
endmodule // adc_control_registers
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ==================================================
	// stimulus and observation
	logic        clock;
	logic        sys_rst;
	logic        wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        wb_ack_o, core_done;
	logic [11:0] core_result;
	logic        conv_start, conv_clk_tick, conv_power_on, conv_done_irq;
	logic [3:0]  ext_channel_sel;
	logic        ext_channel_connect, ext_ref_pin_connect;
	logic [2:0]  input_route;
	logic [1:0]  ref_source_sel, amp_gain_sel;
	logic        amp_enable, amp_input_bandgap, amp_ref_pin_connect, bandgap_on;
	int          n_mismatch, samples_checked, cycle_count;
	logic [31:0] rd_q;    // last read data
	// short aliases of the register offsets
	localparam logic [7:0] A_CTL = adc_ctl_pkg::OFS_CONV_CONTROL;
	localparam logic [7:0] A_SRC = adc_ctl_pkg::OFS_INPUT_CLOCK;
	localparam logic [7:0] A_AMP = adc_ctl_pkg::OFS_REF_AMP;
	localparam logic [7:0] A_BG  = adc_ctl_pkg::OFS_BANDGAP;
	localparam logic [7:0] A_LO  = adc_ctl_pkg::OFS_RESULT_LOW;
	localparam logic [7:0] A_HI  = adc_ctl_pkg::OFS_RESULT_HIGH;

	adc_control_registers i_adc_control_registers (
		.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_done(core_done),
		.core_result(core_result), .conv_start(conv_start), .conv_clk_tick(conv_clk_tick),
		.conv_power_on(conv_power_on), .conv_done_irq(conv_done_irq),
		.ext_channel_sel(ext_channel_sel), .ext_channel_connect(ext_channel_connect),
		.input_route(input_route), .ref_source_sel(ref_source_sel),
		.ext_ref_pin_connect(ext_ref_pin_connect), .amp_enable(amp_enable),
		.amp_input_bandgap(amp_input_bandgap), .amp_ref_pin_connect(amp_ref_pin_connect),
		.amp_gain_sel(amp_gain_sel), .bandgap_on(bandgap_on)
	);

	// ==================================================
	// clock and hang guard
	always #5 clock = ~clock;
	// the whole run needs about 800 cycles, so this ceiling only trips on a hang
	always @(posedge clock) begin
		cycle_count++;
		if (cycle_count == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ==================================================
	// helpers
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// classic single cycle; ack and read data are taken at the rising edge that
	// sees ack high, before that edge's own updates land, and released right then
	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h0, dat};
		wb_sel_i <= 4'h1;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd_q = wb_dat_o;
		chk(32'(wb_ack_o), 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		bus(1'b1, adr, dat);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
		bus(1'b0, adr, 8'h00);
		chk(rd_q, {24'h0, exp});
	endtask

	// completion from the analog core, one cycle long
	task automatic core_finish(input logic [11:0] res);
		@(posedge clock);
		core_done   <= 1'b1;
		core_result <= res;
		@(posedge clock);
		core_done   <= 1'b0;
		core_result <= 12'h555;
		@(negedge clock);
	endtask

	// ==================================================
	// scenarios
	task automatic t_reset;
		for (int a = 0; a <= 24; a += 4) rd_chk(8'(a), 8'h00);
		chk({28'h0, ext_channel_connect, amp_ref_pin_connect, conv_power_on, bandgap_on},
			32'hc);
	endtask

	task automatic t_ref_regs;
		wr(A_BG, 8'hff); // bandgap on before it feeds the amplifier
		rd_chk(A_BG, 8'h01);
		chk(32'(bandgap_on), 32'h1);
		repeat (20) @(negedge clock); // bandgap settling time
		wr(A_AMP, 8'hff);
		rd_chk(A_AMP, 8'h9f);
		chk({amp_enable, amp_input_bandgap, amp_ref_pin_connect}, 3'b110);
		// each reference code paired with the same gain code
		for (int i = 0; i < 4; i++) begin
			wr(A_AMP, {4'h0, 2'(i), 2'(i)});
			@(negedge clock);
			chk({ref_source_sel, amp_gain_sel, ext_ref_pin_connect, amp_ref_pin_connect},
				{2'(i), 2'(i), i == 1, 1'b1});
		end
		wr(A_SRC, 8'hff);
		rd_chk(A_SRC, 8'hf7);
		wr(8'h18, 8'hff);
		rd_chk(8'h18, 8'h00);
		wr(A_HI, 8'hff);
		rd_chk(A_HI, 8'h00);
		wr(A_BG, 8'h00);
		@(negedge clock);
		chk(32'(bandgap_on), 32'h0);
	endtask

	task automatic t_routing;
		logic [2:0] er;
		for (int c = 0; c < 16; c++) begin
			case (c)
				1, 2, 3:       er = 3'(c);
				5, 6, 7:       er = 3'(c - 1);
				8, 9, 10, 11:  er = 3'h7;
				default:       er = 3'h0;
			endcase
			wr(A_SRC, {4'(c), 4'h0});
			@(negedge clock);
			chk({input_route, ext_channel_connect}, {er, er == 3'h0});
		end
	endtask

	task automatic t_channels;
		logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hb, 4'hd, 4'he, 4'hf};
		foreach (codes[i]) begin
			wr(A_CTL, {4'h2, codes[i]});
			@(negedge clock);
			chk({conv_power_on, ext_channel_sel}, {1'b1, codes[i]});
			rd_chk(A_CTL, {4'h2, codes[i]});
		end
	endtask

	task automatic t_divider;
		int n;
		for (int d = 0; d < 8; d++) begin
			wr(A_SRC, {5'h0, 3'(d)});
			// let the divider restart on the new select, so that no tick of
			// the old period is taken as the first one
			repeat (2) @(negedge clock);
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (conv_clk_tick !== 1'b1 && n < 300);
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (conv_clk_tick !== 1'b1 && n < 300);
			chk(32'(n), 32'(1 << d));
		end
	endtask

	task automatic t_conversion;
		wr(A_CTL, 8'h6d);
		rd_chk(A_CTL, 8'h2d);
		wr(A_CTL, 8'had);
		chk(32'(conv_start), 32'h0);
		wr(A_CTL, 8'h2d);
		@(negedge clock);
		chk(32'(conv_start), 32'h1);
		rd_chk(A_CTL, 8'h6d);
		core_finish(12'habc);
		chk(32'(conv_done_irq), 32'h1);
		rd_chk(A_CTL, 8'h2d);
		rd_chk(A_HI, 8'hab);
		rd_chk(A_LO, 8'hc0);
		wr(A_CTL, 8'h3d);
		rd_chk(A_HI, 8'h0a);
		rd_chk(A_LO, 8'hbc);
	endtask

	// switching off aborts a running conversion, and a start sequence with
	// the converter off must be ignored; the result stays as it was
	task automatic t_disabled;
		wr(A_CTL, 8'had);
		wr(A_CTL, 8'h2d);
		rd_chk(A_CTL, 8'h6d);
		wr(A_CTL, 8'h0d);
		rd_chk(A_CTL, 8'h0d);
		wr(A_CTL, 8'h8d);
		wr(A_CTL, 8'h0d);
		repeat (3) begin
			@(negedge clock);
			chk({conv_start, conv_power_on}, 2'b00);
		end
		rd_chk(A_CTL, 8'h0d);
		core_finish(12'h123);
		chk(32'(conv_done_irq), 32'h0);
		rd_chk(A_HI, 8'hab);
	endtask

	// ==================================================
	// main sequence
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, core_done} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		core_result = 12'h000;
		n_mismatch = 0;
		samples_checked = 0;
		cycle_count = 0;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_ref_regs();
		t_routing();
		t_channels();
		t_divider();
		t_conversion();
		t_disabled();
		give_verdict();
	end
endmodule // tb
`default_nettype wire
